//--- rtl/aomc_pkg.sv
package aomc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int ODR_BASE_HZ = 400;
  localparam int ODR_CYCLES = CLK_HZ / ODR_BASE_HZ;
  localparam logic [2:0] ODR_MAX_CODE = 3'h4;
  localparam logic [16:0] EXT_EDGES_PER_MS = 17'h0_0020;
  localparam logic [14:0] SETTLE_LONG_MS = 15'h0172;
  localparam logic [14:0] SETTLE_SHORT_MS = 15'h0010;
  localparam logic [14:0] WAKE_MS [8] = '{15'h0034, 15'h0068, 15'h00d0, 15'h0200,
                                         15'h0800, 15'h1000, 15'h2000, 15'h6000};
  localparam logic [7:0] IMPACT_LOW_G = 8'h0a;
  localparam logic [7:0] IMPACT_HIGH_G = 8'h1e;
  localparam logic [7:0] ADDR_POWER = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_ACTION = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_SETTLE_BIT = 2;
  localparam int PWR_HITHR_BIT = 3;
  localparam int PWR_EXTCLK_BIT = 4;
  localparam int PWR_EXTTRIG_BIT = 5;
  localparam int TIM_WAKE_LSB = 0;
  localparam int TIM_ODR_LSB = 3;
  localparam int TIM_BW_LSB = 6;
  localparam int ACT_MEAS_BIT = 0;
  localparam int ACT_IRQ_BIT = 1;
  localparam int ACT_WAKE_BIT = 2;
  localparam int ACT_EN1_BIT = 3;
  localparam int ACT_EN2_BIT = 4;
  localparam logic [5:0] POWER_RST = 6'h00;
  localparam logic [8:0] TIMING_RST = 9'h000;
  localparam logic [4:0] ACTION_RST = 5'h19;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0, MODE_WAKE = 2'h1, MODE_INSTANT = 2'h2, MODE_MEASURE = 2'h3
  } aomc_mode_t;
  typedef enum logic [5:0] {
    ST_STBY = 6'h01, ST_INST = 6'h02, ST_WOFF = 6'h04,
    ST_WON = 6'h08, ST_SETL = 6'h10, ST_MEAS = 6'h20
  } aomc_state_t;
endpackage

//--- rtl/aomc_top.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
module aomc_top #(
  parameter int MS_CYCLES = aomc_pkg::MS_CYCLES,
  parameter int ODR_CYCLES = aomc_pkg::ODR_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] impact_g,
  input wire logic motion_event,
  input wire logic irq_src_one,
  input wire logic irq_src_two,
  input wire logic [11:0] sample_in,
  input wire logic sample_in_valid,
  output logic conv_start,
  output logic [2:0] antialias_bw_sel,
  output logic [11:0] sample_data,
  output logic sample_pub,
  output logic fifo_wr,
  output logic wake_downstream,
  input wire logic irq_line_one_i,
  output logic irq_line_one_o,
  output logic irq_line_one_oe,
  input wire logic irq_line_two_i,
  output logic irq_line_two_o,
  output logic irq_line_two_oe
);
  aomc_pkg::aomc_state_t st_r, st_nxt;
  logic [5:0] power_r;
  logic [8:0] timing_r;
  logic [4:0] action_r;
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic c1_meta_r, c1_sync_r, c1_prev_r, t2_meta_r, t2_sync_r, t2_prev_r;
  logic [16:0] div_r;
  logic [14:0] ms_cnt_r;
  logic [17:0] odr_cnt_r;
  logic [1:0] pend_r;
  logic wake_flag_r, wake_out_r, irq1_r, irq2_r, pub_r, fifo_r;
  logic [11:0] data_r;

  // Register bus decode.
  wire wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  wire rd_fire = s_axi_arvalid & ~rvalid_r;
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire [15:0] wm = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire w_pwr = wr_fire & (aw_addr_r == aomc_pkg::ADDR_POWER);
  wire w_tim = wr_fire & (aw_addr_r == aomc_pkg::ADDR_TIMING);
  wire w_act = wr_fire & (aw_addr_r == aomc_pkg::ADDR_ACTION);
  wire w_ro = (aw_addr_r == aomc_pkg::ADDR_STATUS) | (aw_addr_r == aomc_pkg::ADDR_DATA);
  wire w_map = w_pwr | w_tim | w_act | w_ro;
  wire [5:0] pw_new = (power_r & ~wm[5:0]) | (w_data_r[5:0] & wm[5:0]);
  wire [8:0] tm_new = (timing_r & ~wm[8:0]) | (w_data_r[8:0] & wm[8:0]);
  wire [4:0] ac_new = (action_r & ~wm[4:0]) | (w_data_r[4:0] & wm[4:0]);
  wire rd_st = rd_fire & (raddr == aomc_pkg::ADDR_STATUS);
  wire r_map = (raddr == aomc_pkg::ADDR_POWER) | (raddr == aomc_pkg::ADDR_TIMING) |
               (raddr == aomc_pkg::ADDR_ACTION) | (raddr == aomc_pkg::ADDR_STATUS) |
               (raddr == aomc_pkg::ADDR_DATA);
  wire [31:0] status_w = {22'h00_0000, wake_out_r, wake_flag_r, pend_r, st_r};
  wire [31:0] rd_mux =
    (raddr == aomc_pkg::ADDR_POWER) ? {26'h000_0000, power_r} :
    (raddr == aomc_pkg::ADDR_TIMING) ? {23'h00_0000, timing_r} :
    (raddr == aomc_pkg::ADDR_ACTION) ? {27'h000_0000, action_r} :
    (raddr == aomc_pkg::ADDR_STATUS) ? status_w :
    (raddr == aomc_pkg::ADDR_DATA) ? {20'h0_0000, data_r} : 32'h0000_0000;

  // State decode.
  wire in_stby = (st_r == aomc_pkg::ST_STBY);
  wire in_inst = (st_r == aomc_pkg::ST_INST);
  wire in_woff = (st_r == aomc_pkg::ST_WOFF);
  wire in_won = (st_r == aomc_pkg::ST_WON);
  wire in_setl = (st_r == aomc_pkg::ST_SETL);
  wire in_meas = (st_r == aomc_pkg::ST_MEAS);
  wire in_wake = in_woff | in_won;
  wire [1:0] mode_cur = power_r[aomc_pkg::PWR_MODE_LSB +: 2];
  wire [1:0] mode_new = pw_new[aomc_pkg::PWR_MODE_LSB +: 2];
  wire mode_chg = w_pwr & (mode_new != mode_cur);
  wire ext_clk = power_r[aomc_pkg::PWR_EXTCLK_BIT];
  wire ext_trig = power_r[aomc_pkg::PWR_EXTTRIG_BIT];

  // Time base in milliseconds, from the own clock or from external clock edges.
  wire c1_rise = c1_sync_r & ~c1_prev_r;
  wire t2_rise = t2_sync_r & ~t2_prev_r;
  wire step = ext_clk ? c1_rise : 1'b1;
  wire [16:0] div_lim = ext_clk ? aomc_pkg::EXT_EDGES_PER_MS - 17'h0_0001 :
                        17'(MS_CYCLES - 1);
  wire ms_tick = step & (div_r == div_lim);
  wire [14:0] settle_ms = power_r[aomc_pkg::PWR_SETTLE_BIT] ?
                          aomc_pkg::SETTLE_SHORT_MS : aomc_pkg::SETTLE_LONG_MS;
  wire [14:0] wake_ms = aomc_pkg::WAKE_MS[timing_r[aomc_pkg::TIM_WAKE_LSB +: 3]];
  wire settle_done = ms_tick & (ms_cnt_r == settle_ms - 15'h0001);
  wire wake_done = ms_tick & (ms_cnt_r == wake_ms - 15'h0001);

  // Events that move the mode without a host write.
  wire [7:0] thr = power_r[aomc_pkg::PWR_HITHR_BIT] ?
                   aomc_pkg::IMPACT_HIGH_G : aomc_pkg::IMPACT_LOW_G;
  wire impact_hit = in_inst & (impact_g >= thr);
  wire wake_motion = in_won & motion_event;
  wire auto_go = impact_hit | (wake_motion & action_r[aomc_pkg::ACT_MEAS_BIT]);
  wire st_chg = (st_nxt != st_r);

  always_comb begin
    st_nxt = st_r;
    if (mode_chg) begin
      case (mode_new)
        aomc_pkg::MODE_STANDBY: st_nxt = aomc_pkg::ST_STBY;
        aomc_pkg::MODE_WAKE: st_nxt = aomc_pkg::ST_WOFF;
        aomc_pkg::MODE_INSTANT: st_nxt = aomc_pkg::ST_INST;
        default: st_nxt = aomc_pkg::ST_SETL;
      endcase
    end else if (auto_go) begin
      st_nxt = aomc_pkg::ST_SETL;
    end else begin
      case (st_r)
        aomc_pkg::ST_SETL: if (settle_done) st_nxt = aomc_pkg::ST_MEAS;
        aomc_pkg::ST_WOFF: if (wake_done) st_nxt = aomc_pkg::ST_WON;
        aomc_pkg::ST_WON: if (settle_done) st_nxt = aomc_pkg::ST_WOFF;
        default: st_nxt = st_r;
      endcase
    end
  end

  // Conversion pacing: rate timer, or the trigger on line two.
  wire samp_on = in_setl | in_meas | in_won;
  wire [2:0] odr_in = timing_r[aomc_pkg::TIM_ODR_LSB +: 3];
  wire [2:0] output_sample_rate = (odr_in > aomc_pkg::ODR_MAX_CODE) ? aomc_pkg::ODR_MAX_CODE : odr_in;
  wire [17:0] odr_lim = 18'(ODR_CYCLES >> output_sample_rate) - 18'h0_0001;
  wire odr_done = (odr_cnt_r >= odr_lim);
  wire meas_smp = in_meas & sample_in_valid;
  wire won_smp = in_won & sample_in_valid;
  wire int_ok = in_meas | in_setl | in_inst;
  wire [1:0] pend_set = {irq_src_two, irq_src_one} & {2{int_ok}};
  wire [1:0] pend_nxt = in_stby ? 2'h0 : ((pend_r & ~{2{rd_st}}) | pend_set);
  wire wflag_set = wake_motion & action_r[aomc_pkg::ACT_IRQ_BIT];
  wire wflag_nxt = ~in_stby & ((wake_flag_r & ~rd_st) | wflag_set);
  wire wout_nxt = ~in_stby & (wake_out_r | (wake_motion & action_r[aomc_pkg::ACT_WAKE_BIT]));
  wire nxt_quiet = |(st_nxt & (aomc_pkg::ST_STBY | aomc_pkg::ST_WOFF | aomc_pkg::ST_WON));
  wire irq1_nxt = (pend_r[0] | wake_flag_r) & action_r[aomc_pkg::ACT_EN1_BIT] & ~nxt_quiet;
  wire irq2_nxt = pend_r[1] & action_r[aomc_pkg::ACT_EN2_BIT] & ~nxt_quiet;

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign conv_start = samp_on & (ext_trig ? t2_rise : odr_done);
  assign antialias_bw_sel = timing_r[aomc_pkg::TIM_BW_LSB +: 3];
  assign sample_data = data_r;
  assign sample_pub = pub_r;
  assign fifo_wr = fifo_r;
  assign wake_downstream = wake_out_r;
  assign irq_line_one_o = irq1_r;
  assign irq_line_one_oe = ~ext_clk;
  assign irq_line_two_o = irq2_r;
  assign irq_line_two_oe = ~ext_trig;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= aomc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
      end else if (wr_fire) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid & ~w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= w_map ? aomc_pkg::RESP_OKAY : aomc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= aomc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= r_map ? aomc_pkg::RESP_OKAY : aomc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      power_r <= aomc_pkg::POWER_RST;
      timing_r <= aomc_pkg::TIMING_RST;
      action_r <= aomc_pkg::ACTION_RST;
      st_r <= aomc_pkg::ST_STBY;
    end else begin
      if (w_pwr) power_r <= pw_new;
      if (auto_go & ~mode_chg) power_r[aomc_pkg::PWR_MODE_LSB +: 2] <= aomc_pkg::MODE_MEASURE;
      if (w_tim) timing_r <= tm_new;
      if (w_act) action_r <= ac_new;
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      c1_meta_r <= 1'b0;
      c1_sync_r <= 1'b0;
      c1_prev_r <= 1'b0;
      t2_meta_r <= 1'b0;
      t2_sync_r <= 1'b0;
      t2_prev_r <= 1'b0;
      div_r <= 17'h0_0000;
      ms_cnt_r <= 15'h0000;
      odr_cnt_r <= 18'h0_0000;
    end else begin
      c1_meta_r <= irq_line_one_i;
      c1_sync_r <= c1_meta_r;
      c1_prev_r <= c1_sync_r;
      t2_meta_r <= irq_line_two_i;
      t2_sync_r <= t2_meta_r;
      t2_prev_r <= t2_sync_r;
      div_r <= (st_chg | ms_tick) ? 17'h0_0000 : (step ? div_r + 17'h0_0001 : div_r);
      ms_cnt_r <= st_chg ? 15'h0000 : (ms_tick ? ms_cnt_r + 15'h0001 : ms_cnt_r);
      odr_cnt_r <= (~samp_on | odr_done) ? 18'h0_0000 : odr_cnt_r + 18'h0_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_r <= 2'h0;
      wake_flag_r <= 1'b0;
      wake_out_r <= 1'b0;
      irq1_r <= 1'b0;
      irq2_r <= 1'b0;
      pub_r <= 1'b0;
      fifo_r <= 1'b0;
      data_r <= 12'h000;
    end else begin
      pend_r <= pend_nxt;
      wake_flag_r <= wflag_nxt;
      wake_out_r <= wout_nxt;
      irq1_r <= irq1_nxt;
      irq2_r <= irq2_nxt;
      pub_r <= meas_smp;
      fifo_r <= meas_smp;
      if (meas_smp | won_smp) data_r <= sample_in;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_off_end;
    in_woff && wake_done && !mode_chg;
  endsequence
  sequence s_on_phase;
    in_won [*2];
  endsequence

  a_standby_clears: assert property (in_stby |=> pend_r == 2'h0 && !wake_flag_r)
    else $error("pending interrupt survives standby");
  a_wake_quiet: assert property (in_wake |-> !irq_line_one_o && !irq_line_two_o)
    else $error("interrupt line asserted in wake-up");
  a_fifo_only_meas: assert property (fifo_wr |-> $past(in_meas))
    else $error("fifo write outside measurement");
  a_pub_only_meas: assert property (sample_pub |-> $past(in_meas) && fifo_wr)
    else $error("sample published outside measurement");
  a_settle_withhold: assert property (in_setl |=> !sample_pub)
    else $error("sample published during settling");
  a_impact_switch: assert property (impact_hit && !mode_chg |=>
    in_setl && mode_cur == aomc_pkg::MODE_MEASURE)
    else $error("impact did not switch to measurement");
  a_wake_data: assert property (won_smp |=> sample_data == $past(sample_in) && !fifo_wr)
    else $error("wake-up data register not updated");
  a_reset_standby: assert property ($fell(sys_rst) |-> in_stby && !conv_start)
    else $error("device not in standby after reset");
  a_wake_cycle: assert property (s_off_end |=> s_on_phase or (in_won ##1 !in_won))
    else $error("off-phase end did not power on");
  a_standby_write: assert property (mode_chg && mode_new == aomc_pkg::MODE_STANDBY |=>
    in_stby ##1 !conv_start)
    else $error("standby write not honoured");
endmodule

//--- testbench/aomc_far_end.sv
module aomc_far_end (
  input wire logic clock,
  input wire logic conv_start,
  input wire logic ext_clk_en,
  output logic [11:0] sample_in,
  output logic sample_in_valid,
  output logic [11:0] last_sample,
  output logic link_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly_r;
  initial begin
    sample_in = 12'h0a5;
    sample_in_valid = 1'b0;
    last_sample = 12'h0a5;
    link_clk = 1'b0;
    dly_r = 2'h0;
  end
  // A result comes three cycles after its start; between results the data bus shows junk.
  always @(posedge clock) begin
    dly_r <= {dly_r[0], conv_start};
    sample_in_valid <= dly_r[1];
    if (dly_r[1]) begin
      sample_in <= last_sample + 12'h013;
      last_sample <= last_sample + 12'h013;
    end else begin
      sample_in <= ~last_sample;
    end
  end
  // The external clock runs only while the line is handed over, at an unrelated phase.
  initial begin
    #3;
    forever begin
      #80;
      link_clk = ext_clk_en ? ~link_clk : 1'b0;
    end
  end
endmodule

//--- testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awa_r = 8'h00, ara_r = 8'h00, impact_r = 8'h00;
  logic [31:0] wd_r = 32'h0000_0000;
  logic awv_r = 0, wv_r = 0, br_r = 0, arv_r = 0, rr_r = 0;
  logic src1_r = 0, src2_r = 0, motion_r = 0, trig_r = 0;
  wire awr, wrdy, bv, arr, rv, conv, sv, pub, fwr, wake, o1, oe1, o2, oe2, lclk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] sin, sdat, last;
  wire [2:0] bw;
  logic [31:0] d;
  logic [1:0] r;
  int bad_count = 0, checks_done = 0, cyc = 0, pub_n = 0, fifo_n = 0, conv_n = 0;
  int first_pub = 0, ts, el, n, p, f;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    pub_n += int'(pub);
    fifo_n += int'(fwr);
    conv_n += int'(conv);
    if (pub && first_pub == 0) first_pub = cyc;
  end
  aomc_top #(.MS_CYCLES(20), .ODR_CYCLES(64)) dut (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr({24'h00_0000, awa_r}),
    .s_axi_awvalid(awv_r), .s_axi_awready(awr), .s_axi_wdata(wd_r), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv_r), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br_r), .s_axi_araddr({24'h00_0000, ara_r}), .s_axi_arvalid(arv_r),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr_r), .impact_g(impact_r), .motion_event(motion_r), .irq_src_one(src1_r),
    .irq_src_two(src2_r), .sample_in(sin), .sample_in_valid(sv), .conv_start(conv),
    .antialias_bw_sel(bw), .sample_data(sdat), .sample_pub(pub), .fifo_wr(fwr),
    .wake_downstream(wake), .irq_line_one_i(oe1 ? o1 : lclk), .irq_line_one_o(o1),
    .irq_line_one_oe(oe1), .irq_line_two_i(oe2 ? o2 : trig_r), .irq_line_two_o(o2),
    .irq_line_two_oe(oe2));
  aomc_far_end far (.clock(clock), .conv_start(conv), .ext_clk_en(!oe1), .sample_in(sin),
    .sample_in_valid(sv), .last_sample(last), .link_clk(lclk));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic guard(input int k);
    if (k > 3000) begin
      chk("wait bound", 32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    logic ha, hw, hb;
    awa_r <= a;
    wd_r <= v;
    awv_r <= 1'b1;
    wv_r <= 1'b1;
    br_r <= 1'b1;
    k = 0;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clock);
      ha = awr;
      hw = wrdy;
      hb = bv;
      r = bresp;
      @(posedge clock);
      if (ha) awv_r <= 1'b0;
      if (hw) wv_r <= 1'b0;
      if (hb) br_r <= 1'b0;
      k++;
      guard(k);
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
    @(posedge clock);
  endtask
  task automatic bus_rd(input logic [7:0] a);
    int k;
    logic ha, hr;
    ara_r <= a;
    arv_r <= 1'b1;
    rr_r <= 1'b1;
    k = 0;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clock);
      ha = arr;
      hr = rv;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ha) arv_r <= 1'b0;
      if (hr) rr_r <= 1'b0;
      k++;
      guard(k);
    end
    @(posedge clock);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    chk(nm, e, d);
  endtask
  task automatic wait_st(input logic [5:0] e);
    int k;
    k = 0;
    do begin
      bus_rd(8'h0c);
      k++;
      guard(k);
    end while (d[5:0] !== e);
    el = cyc - ts;
  endtask
  task automatic irq_pulse(input bit two);
    if (two) src2_r <= 1'b1;
    else src1_r <= 1'b1;
    @(posedge clock);
    src1_r <= 1'b0;
    src2_r <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdc("power", 8'h00, 32'h0);
    rdc("timing", 8'h04, 32'h0);
    chk("bandwidth", 32'h0, {29'h0, bw});
    rdc("action", 8'h08, 32'h19);
    rdc("status", 8'h0c, 32'h1);
    bus_rd(8'h20);
    chk("rresp", 32'h2, {30'h0, r});
    bus_wr(8'h20, 32'h1, 2'h2);
    bus_wr(8'h04, 32'h0000_0148, 2'h0);
    chk("bandwidth", 32'h5, {29'h0, bw});
    $display("test reset done");
    first_pub = 0;
    ts = cyc;
    bus_wr(8'h00, 32'h7, 2'h0);
    wait_st(6'h20);
    chk("settle time", 32'h1, 32'(el >= 318 && el <= 335));
    chk("first sample", 32'h1, 32'(first_pub == 0 || first_pub - ts >= 320));
    n = conv_n;
    p = pub_n;
    f = fifo_n;
    repeat (320) @(posedge clock);
    chk("rate", 32'h1, 32'(conv_n - n >= 9 && conv_n - n <= 11));
    chk("fifo", 32'(pub_n - p), 32'(fifo_n - f));
    chk("published", 32'h1, 32'(pub_n > p));
    bus_wr(8'h04, 32'h0000_0178, 2'h0);
    n = conv_n;
    repeat (64) @(posedge clock);
    chk("max rate", 32'h1, 32'(conv_n - n >= 15 && conv_n - n <= 17));
    bus_wr(8'h04, 32'h0000_0148, 2'h0);
    irq_pulse(1'b0);
    chk("line one", 32'h1, {31'h0, o1});
    irq_pulse(1'b1);
    chk("line two", 32'h1, {31'h0, o2});
    rdc("status", 8'h0c, 32'he0);
    irq_pulse(1'b0);
    bus_wr(8'h00, 32'h0, 2'h0);
    chk("line one", 32'h0, {31'h0, o1});
    irq_pulse(1'b1);
    chk("line two", 32'h0, {31'h0, o2});
    rdc("status", 8'h0c, 32'h1);
    n = conv_n;
    repeat (200) @(posedge clock);
    chk("standby conv", 32'h0, 32'(conv_n - n));
    $display("test measure done");
    for (int i = 0; i < 2; i++) begin
      bus_wr(8'h00, i ? 32'ha : 32'h2, 2'h0);
      impact_r <= i ? 8'h1d : 8'h09;
      p = pub_n;
      repeat (50) @(posedge clock);
      rdc("status", 8'h0c, 32'h2);
      chk("instant pub", 32'h0, 32'(pub_n - p));
      rdc("power", 8'h00, i ? 32'ha : 32'h2);
      impact_r <= i ? 8'h1e : 8'h0a;
      repeat (3) @(posedge clock);
      rdc("status", 8'h0c, 32'h10);
      rdc("power", 8'h00, i ? 32'hb : 32'h3);
      impact_r <= 8'h00;
      bus_wr(8'h00, 32'h0, 2'h0);
    end
    $display("test instant done");
    bus_wr(8'h08, 32'h1f, 2'h0);
    bus_wr(8'h00, 32'h5, 2'h0);
    ts = cyc;
    rdc("status", 8'h0c, 32'h4);
    wait_st(6'h08);
    chk("wake interval", 32'h1, 32'(el >= 1030 && el <= 1050));
    p = pub_n;
    f = fifo_n;
    irq_pulse(1'b0);
    chk("line one", 32'h0, {31'h0, o1});
    n = 0;
    while (!sv) begin
      @(posedge clock);
      n++;
      guard(n);
    end
    repeat (2) @(posedge clock);
    rdc("data", 8'h10, {20'h0, last});
    chk("sample data", {20'h0, last}, {20'h0, sdat});
    chk("wake fifo", 32'h0, 32'(fifo_n - f));
    motion_r <= 1'b1;
    repeat (3) @(posedge clock);
    motion_r <= 1'b0;
    chk("wake out", 32'h1, {31'h0, wake});
    chk("wake flag line", 32'h1, {31'h0, o1});
    rdc("status", 8'h0c, 32'h310);
    bus_wr(8'h00, 32'h0, 2'h0);
    $display("test wake done");
    ts = cyc;
    bus_wr(8'h00, 32'h17, 2'h0);
    chk("line one oe", 32'h0, {31'h0, oe1});
    wait_st(6'h20);
    chk("ext settle", 32'h1, 32'(el >= 8180 && el <= 8240));
    bus_wr(8'h00, 32'h0, 2'h0);
    bus_wr(8'h00, 32'h27, 2'h0);
    chk("line two oe", 32'h0, {31'h0, oe2});
    n = conv_n;
    repeat (100) @(posedge clock);
    trig_r <= 1'b1;
    repeat (4) @(posedge clock);
    trig_r <= 1'b0;
    repeat (200) @(posedge clock);
    chk("trigger conv", 32'h1, 32'(conv_n - n));
    bus_wr(8'h00, 32'h0, 2'h0);
    $display("test external done");
    finish_test();
  end
endmodule
